// ---- hw/brf_defs.svh ----
// Purpose: Constants for the banked processor register file.
// Assumes: Included by the package and the register file module.
// Notes:   Field positions, reset values and operand codes live here.
`ifndef BRF_DEFS_SVH
`define BRF_DEFS_SVH

`define BRF_XLEN           32
`define BRF_GPR_IDX_W      4
`define BRF_LOW_COUNT      8
`define BRF_LOW_IDX_W      3
`define BRF_HIGH_BIT       3

// Status word fields.
`define BRF_ST_PRIV_BIT    30
`define BRF_ST_BANK_BIT    29
`define BRF_ST_BLOCK_BIT   28
`define BRF_ST_EXT_BIT     12
`define BRF_ST_WMASK       32'h700013F3
`define BRF_ST_RESET       32'h700000F0
`define BRF_VECTOR_RESET   32'h00000000
`define BRF_ZERO_WORD      32'h00000000

// Control load/store operand codes; codes with bit 3 set name a hidden bank entry.
`define BRF_CTL_SEL_W      4
`define BRF_CTL_STATUS     4'h0
`define BRF_CTL_SAVED_ST   4'h1
`define BRF_CTL_SAVED_IP   4'h2
`define BRF_CTL_GLOBAL     4'h3
`define BRF_CTL_VECTOR     4'h4
`define BRF_CTL_REP_START  4'h5
`define BRF_CTL_REP_END    4'h6
`define BRF_CTL_WRAP       4'h7
`define BRF_CTL_BANK_BIT   3

`endif

// ---- hw/brf_pkg.sv ----
// Purpose: Types shared by the banked register file.
// Assumes: brf_defs.svh supplies the numeric constants.
// Notes:   Holds types only.
`include "brf_defs.svh"
package brf_pkg;
   typedef logic [`BRF_XLEN-1:0] brf_word_t;
   typedef enum logic [1:0] {
      BRF_SYS_MULT_HIGH = 2'h0,
      BRF_SYS_MULT_LOW  = 2'h1,
      BRF_SYS_RET_LINK  = 2'h2
   } brf_sys_sel_e;
endpackage

// ---- hw/brf_regfile.sv ----
// Purpose: Architectural register file with two banks for the low eight general registers.
// Assumes: Inputs synchronous to clk; one general write, one control and one system op
//          per cycle; the decoder never issues a control and system op in the same cycle.
// Notes:   Read data is registered, so it reflects the state before the same-cycle write.
// Behaviour
// - All general, control, system registers 32 bits.
// - Low eight general registers exist in two banks.
// - Privileged: bank bit picks the general bank.
// - Hidden bank reached only by control load/store.
// - Control load/store moves all eight control registers.
// - User mode reaches only global, repeat, wrap.
// - Repeat and wrap registers need extension mode.
// - System load/store reaches multiply and return.
// - Instruction pointer only saved/restored on exceptions.
// - Privilege bit selects user or privileged view.
// - Extension bit in status gates extension registers.
// - Register zero supplies the index operand.
// - Sixteen general registers numbered zero to fifteen.
// - Reset: privileged, bank one, block, mask ones.
`include "brf_defs.svh"
module brf_regfile
   import brf_pkg::*;
(
   input  wire logic                       clk,
   input  wire logic                       sys_rst,
   input  wire logic [`BRF_GPR_IDX_W-1:0]  rd_a_idx,
   input  wire logic [`BRF_GPR_IDX_W-1:0]  rd_b_idx,
   input  wire logic                       gpr_we,
   input  wire logic [`BRF_GPR_IDX_W-1:0]  gpr_widx,
   input  wire brf_word_t                  gpr_wdata,
   input  wire logic                       ctl_op,
   input  wire logic                       ctl_load,
   input  wire logic [`BRF_CTL_SEL_W-1:0]  ctl_sel,
   input  wire brf_word_t                  ctl_wdata,
   input  wire logic                       sys_op,
   input  wire logic                       sys_load,
   input  wire brf_sys_sel_e               sys_sel,
   input  wire brf_word_t                  sys_wdata,
   input  wire logic                       exc_entry,
   input  wire brf_word_t                  cur_ip,
   input  wire logic                       exc_return,
   output logic                            priv_mode_q,
   output logic                            ext_mode_q,
   output brf_word_t                       status_word_q,
   output brf_word_t                       rd_a_data_q,
   output brf_word_t                       rd_b_data_q,
   output brf_word_t                       index_data_q,
   output brf_word_t                       ctl_rdata_q,
   output logic                            ctl_fault_q,
   output brf_word_t                       sys_rdata_q,
   output brf_word_t                       resume_ip_q,
   output logic                            resume_valid_q
);

   // ***************************************************************
   // Storage
   // ***************************************************************
   brf_word_t low_gpr_bank_zero [`BRF_LOW_COUNT];
   brf_word_t low_gpr_bank_one  [`BRF_LOW_COUNT];
   brf_word_t high_gpr          [`BRF_LOW_COUNT];
   brf_word_t saved_status_word_q;
   brf_word_t saved_ip_q;
   brf_word_t global_base_q;
   brf_word_t vector_base_q;
   brf_word_t repeat_start_q;
   brf_word_t repeat_end_q;
   brf_word_t wrap_bounds_reg_q;
   brf_word_t mult_acc_high_q;
   brf_word_t mult_acc_low_q;
   brf_word_t return_link_q;
   brf_word_t status_word_d;

   // ***************************************************************
   // Mode and bank decode
   // ***************************************************************
   wire logic privilege_mode_bit = status_word_q[`BRF_ST_PRIV_BIT];
   wire logic bank_select_bit    = status_word_q[`BRF_ST_BANK_BIT];
   wire logic ext_on             = status_word_q[`BRF_ST_EXT_BIT];
   // User mode ignores the bank bit so user code never sees handler state.
   wire logic cur_bank = privilege_mode_bit & bank_select_bit;

   // A general operand only ever reaches the current bank, never the hidden one.
   function automatic brf_word_t gpr_read(input logic [`BRF_GPR_IDX_W-1:0] idx);
      logic [`BRF_LOW_IDX_W-1:0] li;
      li = idx[`BRF_LOW_IDX_W-1:0];
      if (idx[`BRF_HIGH_BIT]) begin
         return high_gpr[li];
      end else if (cur_bank) begin
         return low_gpr_bank_one[li];
      end else begin
         return low_gpr_bank_zero[li];
      end
   endfunction

   // ***************************************************************
   // Control load/store decode
   // ***************************************************************
   wire logic ctl_is_bank = ctl_sel[`BRF_CTL_BANK_BIT];
   wire logic [`BRF_LOW_IDX_W-1:0] ctl_bidx = ctl_sel[`BRF_LOW_IDX_W-1:0];
   wire logic ctl_is_ext = ~ctl_is_bank &&
      (ctl_sel == `BRF_CTL_REP_START || ctl_sel == `BRF_CTL_REP_END ||
       ctl_sel == `BRF_CTL_WRAP);
   wire logic ctl_user_ok = ctl_is_ext || ctl_sel == `BRF_CTL_GLOBAL;
   wire logic ctl_bad = ctl_op &&
      ((~privilege_mode_bit && ~ctl_user_ok) ||
       (ctl_is_ext && ~ext_on));
   wire logic ctl_wr = ctl_op && ctl_load && ~ctl_bad;
   wire logic ctl_bank_wr = ctl_wr && ctl_is_bank;
   wire logic sys_wr = sys_op && sys_load;

   brf_word_t ctl_rmux;
   always_comb begin
      ctl_rmux = `BRF_ZERO_WORD;
      if (ctl_is_bank) begin
         // The bank that is not current is the one reached here.
         ctl_rmux = cur_bank ? low_gpr_bank_zero[ctl_bidx]
                             : low_gpr_bank_one[ctl_bidx];
      end else begin
         case (ctl_sel)
            `BRF_CTL_STATUS:    ctl_rmux = status_word_q;
            `BRF_CTL_SAVED_ST:  ctl_rmux = saved_status_word_q;
            `BRF_CTL_SAVED_IP:  ctl_rmux = saved_ip_q;
            `BRF_CTL_GLOBAL:    ctl_rmux = global_base_q;
            `BRF_CTL_VECTOR:    ctl_rmux = vector_base_q;
            `BRF_CTL_REP_START: ctl_rmux = repeat_start_q;
            `BRF_CTL_REP_END:   ctl_rmux = repeat_end_q;
            `BRF_CTL_WRAP:      ctl_rmux = wrap_bounds_reg_q;
            default:            ctl_rmux = `BRF_ZERO_WORD;
         endcase
      end
   end

   brf_word_t sys_rmux;
   always_comb begin
      case (sys_sel)
         BRF_SYS_MULT_HIGH: sys_rmux = mult_acc_high_q;
         BRF_SYS_MULT_LOW:  sys_rmux = mult_acc_low_q;
         BRF_SYS_RET_LINK:  sys_rmux = return_link_q;
         default:           sys_rmux = `BRF_ZERO_WORD;
      endcase
   end

   // ***************************************************************
   // Status word next value
   // ***************************************************************
   // Exception entry wins over a same-cycle control write of the status word.
   always_comb begin
      status_word_d = status_word_q;
      if (exc_entry) begin
         status_word_d[`BRF_ST_PRIV_BIT]  = 1'b1;
         status_word_d[`BRF_ST_BANK_BIT]  = 1'b1;
         status_word_d[`BRF_ST_BLOCK_BIT] = 1'b1;
      end else if (exc_return) begin
         status_word_d = saved_status_word_q & `BRF_ST_WMASK;
      end else if (ctl_wr && ~ctl_is_bank && ctl_sel == `BRF_CTL_STATUS) begin
         status_word_d = ctl_wdata & `BRF_ST_WMASK;
      end
   end

   // ***************************************************************
   // Sequential state
   // ***************************************************************
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         status_word_q <= `BRF_ST_RESET;
         vector_base_q <= `BRF_VECTOR_RESET;
      end else begin
         status_word_q <= status_word_d;
         if (ctl_wr && ~ctl_is_bank && ctl_sel == `BRF_CTL_VECTOR) begin
            vector_base_q <= ctl_wdata;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (exc_entry) begin
         saved_status_word_q <= status_word_q;
         saved_ip_q          <= cur_ip;
      end else if (ctl_wr && ~ctl_is_bank) begin
         if (ctl_sel == `BRF_CTL_SAVED_ST) saved_status_word_q <= ctl_wdata;
         if (ctl_sel == `BRF_CTL_SAVED_IP) saved_ip_q <= ctl_wdata;
      end
      if (ctl_wr && ~ctl_is_bank) begin
         if (ctl_sel == `BRF_CTL_GLOBAL)    global_base_q     <= ctl_wdata;
         if (ctl_sel == `BRF_CTL_REP_START) repeat_start_q    <= ctl_wdata;
         if (ctl_sel == `BRF_CTL_REP_END)   repeat_end_q      <= ctl_wdata;
         if (ctl_sel == `BRF_CTL_WRAP)      wrap_bounds_reg_q <= ctl_wdata;
      end
      if (sys_wr && sys_sel == BRF_SYS_MULT_HIGH) mult_acc_high_q <= sys_wdata;
      if (sys_wr && sys_sel == BRF_SYS_MULT_LOW)  mult_acc_low_q  <= sys_wdata;
      if (sys_wr && sys_sel == BRF_SYS_RET_LINK)  return_link_q   <= sys_wdata;
   end

   // General writes go to the current bank; control writes to the hidden one,
   // so the two never collide on one entry.
   always_ff @(posedge clk) begin
      if (gpr_we && gpr_widx[`BRF_HIGH_BIT]) begin
         high_gpr[gpr_widx[`BRF_LOW_IDX_W-1:0]] <= gpr_wdata;
      end
      if ((gpr_we && ~gpr_widx[`BRF_HIGH_BIT] && ~cur_bank) || (ctl_bank_wr && cur_bank)) begin
         low_gpr_bank_zero[ctl_bank_wr && cur_bank ? ctl_bidx
                           : gpr_widx[`BRF_LOW_IDX_W-1:0]] <= ctl_bank_wr && cur_bank
                           ? ctl_wdata : gpr_wdata;
      end
      if ((gpr_we && ~gpr_widx[`BRF_HIGH_BIT] && cur_bank) || (ctl_bank_wr && ~cur_bank)) begin
         low_gpr_bank_one[ctl_bank_wr && ~cur_bank ? ctl_bidx
                          : gpr_widx[`BRF_LOW_IDX_W-1:0]] <= ctl_bank_wr && ~cur_bank
                          ? ctl_wdata : gpr_wdata;
      end
   end

   // ***************************************************************
   // Registered outputs
   // ***************************************************************
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rd_a_data_q    <= `BRF_ZERO_WORD;
         rd_b_data_q    <= `BRF_ZERO_WORD;
         index_data_q   <= `BRF_ZERO_WORD;
         ctl_rdata_q    <= `BRF_ZERO_WORD;
         ctl_fault_q    <= 1'b0;
         sys_rdata_q    <= `BRF_ZERO_WORD;
         resume_ip_q    <= `BRF_ZERO_WORD;
         resume_valid_q <= 1'b0;
         priv_mode_q    <= 1'b1;
         ext_mode_q     <= 1'b0;
      end else begin
         rd_a_data_q    <= gpr_read(rd_a_idx);
         rd_b_data_q    <= gpr_read(rd_b_idx);
         index_data_q   <= gpr_read(`BRF_GPR_IDX_W'(0));
         ctl_rdata_q    <= (ctl_op && ~ctl_load && ~ctl_bad) ? ctl_rmux : `BRF_ZERO_WORD;
         ctl_fault_q    <= ctl_bad;
         sys_rdata_q    <= (sys_op && ~sys_load) ? sys_rmux : `BRF_ZERO_WORD;
         resume_ip_q    <= exc_return ? saved_ip_q : resume_ip_q;
         resume_valid_q <= exc_return && ~exc_entry;
         priv_mode_q    <= status_word_d[`BRF_ST_PRIV_BIT];
         ext_mode_q     <= status_word_d[`BRF_ST_EXT_BIT];
      end
   end

   // ***************************************************************
   // Assertions
   // ***************************************************************
   sequence s_mult_write;
      sys_op && sys_load && sys_sel == BRF_SYS_MULT_HIGH && !exc_entry;
   endsequence
   sequence s_mult_read;
      sys_op && !sys_load && sys_sel == BRF_SYS_MULT_HIGH;
   endsequence

   AST_RESET_STATUS: assert property (@(posedge clk) sys_rst |=>
      status_word_q == `BRF_ST_RESET && priv_mode_q)
      else $error("status word wrong after reset");
   AST_RESERVED_ZERO: assert property (@(posedge clk) disable iff (sys_rst)
      (status_word_q & ~`BRF_ST_WMASK) == `BRF_ZERO_WORD)
      else $error("reserved status bits not zero");
   AST_USER_FAULT: assert property (@(posedge clk) disable iff (sys_rst)
      ctl_op && !privilege_mode_bit && ctl_sel == `BRF_CTL_VECTOR |=> ctl_fault_q)
      else $error("user access to vector base not refused");
   AST_EXT_GATE: assert property (@(posedge clk) disable iff (sys_rst)
      ctl_op && ctl_sel == `BRF_CTL_REP_START && !ext_on |=>
      ctl_fault_q && ctl_rdata_q == `BRF_ZERO_WORD)
      else $error("repeat start reached without extension mode");
   AST_HIDDEN_WRITE: assert property (@(posedge clk) disable iff (sys_rst)
      ctl_bank_wr && cur_bank |=> low_gpr_bank_zero[$past(ctl_bidx)] == $past(ctl_wdata))
      else $error("hidden bank write lost");
   AST_EXC_SAVE: assert property (@(posedge clk) disable iff (sys_rst)
      exc_entry |=> saved_ip_q == $past(cur_ip) && priv_mode_q && cur_bank)
      else $error("exception entry did not save pointer");
   AST_EXC_RESTORE: assert property (@(posedge clk) disable iff (sys_rst)
      exc_return && !exc_entry |=> resume_valid_q && resume_ip_q == $past(saved_ip_q))
      else $error("exception return did not restore pointer");
   AST_INDEX_ZERO: assert property (@(posedge clk) disable iff (sys_rst)
      gpr_we && gpr_widx == '0 && !ctl_op && !exc_entry && !exc_return ##1
      !gpr_we && !ctl_op && !exc_entry && !exc_return |=> index_data_q == $past(gpr_wdata, 2))
      else $error("index operand is not register zero");
   AST_MULT_RW: assert property (@(posedge clk) disable iff (sys_rst)
      s_mult_write ##1 !sys_wr ##1 s_mult_read |=> sys_rdata_q == $past(sys_wdata, 3))
      else $error("multiply-accumulate high read back wrong");
   AST_USER_BANK: assert property (@(posedge clk) disable iff (sys_rst)
      !privilege_mode_bit && !rd_a_idx[`BRF_HIGH_BIT] |=>
      rd_a_data_q == $past(low_gpr_bank_zero[rd_a_idx[`BRF_LOW_IDX_W-1:0]]))
      else $error("user mode read not from bank zero");

endmodule // brf_regfile

// ---- tb/brf_core_model.sv ----
// Purpose: Behavioural decode and execute side that issues requests to the register file.
// Assumes: Requests launch on the falling edge and last exactly one clock.
// Notes:   Idle data lines show the inverse of their last value, never a stale copy.
module brf_core_model
   import brf_pkg::*;
(
   input  wire logic          clk,
   output logic [3:0]         rd_a_idx,
   output logic [3:0]         rd_b_idx,
   output logic               gpr_we,
   output logic [3:0]         gpr_widx,
   output brf_word_t          gpr_wdata,
   output logic               ctl_op,
   output logic               ctl_load,
   output logic [3:0]         ctl_sel,
   output brf_word_t          ctl_wdata,
   output logic               sys_op,
   output logic               sys_load,
   output brf_sys_sel_e       sys_sel,
   output brf_word_t          sys_wdata,
   output logic               exc_entry,
   output brf_word_t          cur_ip,
   output logic               exc_return
);
   timeunit 1ns;
   timeprecision 1ps;
   // ************************************************************
   // Request tasks
   // ************************************************************
   initial begin
      {rd_a_idx, rd_b_idx, gpr_we, gpr_widx, gpr_wdata} = '0;
      {ctl_op, ctl_load, ctl_sel, ctl_wdata, sys_op, sys_load, sys_wdata} = '0;
      {exc_entry, cur_ip, exc_return} = '0;
      sys_sel = BRF_SYS_MULT_HIGH;
   end
   task automatic rd_req(input logic [3:0] idx);
      @(negedge clk);
      rd_a_idx = idx;
      rd_b_idx = idx;
      @(negedge clk);
   endtask
   task automatic gwr(input logic [3:0] idx, input brf_word_t d);
      @(negedge clk);
      gpr_we = 1'b1;
      gpr_widx = idx;
      gpr_wdata = d;
      @(negedge clk);
      gpr_we = 1'b0;
      gpr_wdata = ~d;
   endtask
   task automatic ctl_req(input logic ld, input logic [3:0] sel, input brf_word_t d);
      @(negedge clk);
      ctl_op = 1'b1;
      ctl_load = ld;
      ctl_sel = sel;
      ctl_wdata = d;
      @(negedge clk);
      ctl_op = 1'b0;
      ctl_wdata = ~d;
   endtask
   task automatic sys_req(input logic ld, input brf_sys_sel_e sel, input brf_word_t d);
      @(negedge clk);
      sys_op = 1'b1;
      sys_load = ld;
      sys_sel = sel;
      sys_wdata = d;
      @(negedge clk);
      sys_op = 1'b0;
      sys_wdata = ~d;
   endtask
   task automatic exc_pulse(input logic enter, input brf_word_t ip);
      @(negedge clk);
      exc_entry = enter;
      exc_return = ~enter;
      cur_ip = ip;
      @(negedge clk);
      exc_entry = 1'b0;
      exc_return = 1'b0;
      cur_ip = ~ip;
   endtask
endmodule // brf_core_model

// ---- tb/banked_cpu_register_file_bench.sv ----
// Purpose: Self-checking bench for the banked register file.
// Assumes: Inputs change on the falling edge; results are read one edge after each request.
// Notes:   Bank zero and bank one get distinct values so a wrong bank choice shows at once.
module banked_cpu_register_file_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import brf_pkg::*;
   logic         clk = 1'b0;
   logic         sys_rst = 1'b1;
   logic [3:0]   rd_a_idx, rd_b_idx, gpr_widx, ctl_sel;
   logic         gpr_we, ctl_op, ctl_load, sys_op, sys_load, exc_entry, exc_return;
   brf_word_t    gpr_wdata, ctl_wdata, sys_wdata, cur_ip;
   brf_sys_sel_e sys_sel;
   logic         priv_mode_q, ext_mode_q, ctl_fault_q, resume_valid_q;
   brf_word_t    status_word_q, rd_a_data_q, rd_b_data_q, index_data_q;
   brf_word_t    ctl_rdata_q, sys_rdata_q, resume_ip_q;
   int           miscompares = 0;
   int           check_count = 0;
   int           cyc = 0;
   logic [3:0]   bad_sel [5] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'hB};
   always #5 clk = ~clk;
   brf_regfile i_brf_regfile (.clk, .sys_rst, .rd_a_idx, .rd_b_idx, .gpr_we, .gpr_widx,
      .gpr_wdata, .ctl_op, .ctl_load, .ctl_sel, .ctl_wdata, .sys_op, .sys_load, .sys_sel,
      .sys_wdata, .exc_entry, .cur_ip, .exc_return, .priv_mode_q, .ext_mode_q, .status_word_q,
      .rd_a_data_q, .rd_b_data_q, .index_data_q, .ctl_rdata_q, .ctl_fault_q, .sys_rdata_q,
      .resume_ip_q, .resume_valid_q);
   brf_core_model i_brf_core_model (.clk, .rd_a_idx, .rd_b_idx, .gpr_we, .gpr_widx, .gpr_wdata,
      .ctl_op, .ctl_load, .ctl_sel, .ctl_wdata, .sys_op, .sys_load, .sys_sel, .sys_wdata,
      .exc_entry, .cur_ip, .exc_return);
   // ************************************************************
   // Checking helpers
   // ************************************************************
   task automatic chk(input string what, input brf_word_t exp, input brf_word_t got);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic rdx(input logic [3:0] idx, input brf_word_t exp);
      i_brf_core_model.rd_req(idx);
      chk("rd_a_data_q", exp, rd_a_data_q);
      chk("rd_b_data_q", exp, rd_b_data_q);
   endtask
   task automatic ctlx(input logic ld, input logic [3:0] sel, input brf_word_t d,
                       input brf_word_t exp, input logic flt);
      i_brf_core_model.ctl_req(ld, sel, d);
      chk("ctl_rdata_q", exp, ctl_rdata_q);
      chk("ctl_fault_q", {31'h0, flt}, {31'h0, ctl_fault_q});
   endtask
   task automatic stop_test;
      $display("Comparisons %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // ************************************************************
   // Scenarios
   // ************************************************************
   task automatic t_reset;
      chk("status_word_q", 32'h700000F0, status_word_q);
      chk("priv_mode_q", 32'h1, {31'h0, priv_mode_q});
      chk("ext_mode_q", 32'h0, {31'h0, ext_mode_q});
      ctlx(1'b0, 4'h4, 32'h0, 32'h0, 1'b0);
      ctlx(1'b0, 4'h0, 32'h0, 32'h700000F0, 1'b0);
   endtask
   task automatic t_banks;
      i_brf_core_model.gwr(4'h3, 32'hA1A1A1A1);
      i_brf_core_model.gwr(4'h0, 32'h0B0B0B0B);
      i_brf_core_model.gwr(4'hC, 32'hC0C0C0C0);
      rdx(4'h3, 32'hA1A1A1A1);
      chk("index_data_q", 32'h0B0B0B0B, index_data_q);
      ctlx(1'b1, 4'hB, 32'hB3B3B3B3, 32'h0, 1'b0);
      rdx(4'h3, 32'hA1A1A1A1);
      ctlx(1'b1, 4'h0, 32'h400000F0, 32'h0, 1'b0);
      rdx(4'h3, 32'hB3B3B3B3);
      ctlx(1'b0, 4'hB, 32'h0, 32'hA1A1A1A1, 1'b0);
      rdx(4'hC, 32'hC0C0C0C0);
      i_brf_core_model.gwr(4'hF, 32'hF00DF00D);
      i_brf_core_model.gwr(4'h0, 32'h5A5A5A5A);
      rdx(4'hF, 32'hF00DF00D);
      chk("index_data_q", 32'h5A5A5A5A, index_data_q);
   endtask
   task automatic t_ctl_sys;
      ctlx(1'b0, 4'h5, 32'h0, 32'h0, 1'b1);
      ctlx(1'b1, 4'h7, 32'h77, 32'h0, 1'b1);
      ctlx(1'b1, 4'h0, 32'h400010F0, 32'h0, 1'b0);
      chk("ext_mode_q", 32'h1, {31'h0, ext_mode_q});
      for (int s = 1; s < 8; s++) begin
         ctlx(1'b1, s[3:0], 32'h11110000 + s, 32'h0, 1'b0);
         ctlx(1'b0, s[3:0], 32'h0, 32'h11110000 + s, 1'b0);
      end
      for (int s = 0; s < 3; s++) begin
         i_brf_core_model.sys_req(1'b1, brf_sys_sel_e'(s), 32'h22220000 + s);
         i_brf_core_model.sys_req(1'b0, brf_sys_sel_e'(s), 32'h0);
         chk("sys_rdata_q", 32'h22220000 + s, sys_rdata_q);
      end
   endtask
   task automatic t_user_exc;
      ctlx(1'b1, 4'h0, 32'h20001000, 32'h0, 1'b0);
      chk("priv_mode_q", 32'h0, {31'h0, priv_mode_q});
      rdx(4'h3, 32'hB3B3B3B3);
      ctlx(1'b0, 4'h3, 32'h0, 32'h11110003, 1'b0);
      ctlx(1'b0, 4'h7, 32'h0, 32'h11110007, 1'b0);
      foreach (bad_sel[i]) begin
         ctlx(1'b1, bad_sel[i], 32'hFFFFFFFF, 32'h0, 1'b1);
      end
      chk("status_word_q", 32'h20001000, status_word_q);
      i_brf_core_model.exc_pulse(1'b1, 32'h0C0DE000);
      chk("status_word_q", 32'h70001000, status_word_q);
      rdx(4'h3, 32'hA1A1A1A1);
      ctlx(1'b0, 4'h1, 32'h0, 32'h20001000, 1'b0);
      ctlx(1'b0, 4'h2, 32'h0, 32'h0C0DE000, 1'b0);
      i_brf_core_model.exc_pulse(1'b0, 32'h0);
      chk("resume_ip_q", 32'h0C0DE000, resume_ip_q);
      chk("resume_valid_q", 32'h1, {31'h0, resume_valid_q});
      chk("status_word_q", 32'h20001000, status_word_q);
   endtask
   // ************************************************************
   // Main sequence and watchdog
   // ************************************************************
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         miscompares++;
         stop_test;
      end
   end
   initial begin
      repeat (12) @(negedge clk);
      sys_rst = 1'b0;
      t_reset;
      t_banks;
      t_ctl_sys;
      t_user_exc;
      stop_test;
   end
endmodule // banked_cpu_register_file_bench
